// ===== rtl/dfem_pkg.sv
package dfem_pkg;
	// Error type positions inside counter controls
	localparam int ERR_BDE = 0;
	localparam int ERR_NIT = 1;
	localparam int ERR_UEK = 2;
	localparam int ERR_TYPES = 3;

	// Register indexes; the byte address is four times the index
	localparam logic [11:0] IDX_SOFT_RESET   = 12'h0475;
	localparam logic [11:0] IDX_TEST_CTRL    = 12'h0477;
	localparam logic [11:0] IDX_ILS_MF_COUNT = 12'h0478;
	localparam logic [11:0] IDX_ERR_THRES    = 12'h047C;
	localparam logic [11:0] IDX_SYNC_MASK    = 12'h047D;
	localparam logic [11:0] IDX_LANE0_ERROR_COUNTER_CONTROL   = 12'h0480;
	localparam logic [11:0] IDX_TEST_PATTERN = 12'h0490;
	localparam logic [11:0] IDX_IRQ_STATUS   = 12'h0491;
	localparam logic [11:0] IDX_IRQ_ENABLE   = 12'h0492;
	localparam logic [11:0] IDX_IRQ_CLEAR    = 12'h0493;
	localparam logic [11:0] IDX_SYNC_PENDING = 12'h0494;
	localparam int ADDR_LSB = 2;

	// Field positions
	localparam int SOFT_RESET_BIT     = 3;
	localparam int LINK_TEST_MODE_BIT = 7;
	localparam int REPEAT_TEST_BIT    = 5;
	localparam int QUEUE_MODE_BIT     = 4;
	localparam int AUTO_CLEAR_BIT     = 3;
	localparam int ECNT_ENA_LSB       = 3;
	localparam int ECNT_RST_LSB       = 0;
	localparam int IRQ_PATTERN_BIT    = 3;
	localparam int IRQ_BITS           = 4;

	// Reset values
	localparam logic [7:0]  RST_SOFT_RESET   = 8'h00;
	localparam logic [7:0]  RST_TEST_CTRL    = 8'h00;
	localparam logic [7:0]  RST_ILS_MF_COUNT = 8'h01;
	localparam logic [7:0]  RST_ERR_THRES    = 8'hFF;
	localparam logic [2:0]  RST_SYNC_MASK    = 3'h7;
	localparam logic [5:0]  RST_ECNT_CTRL    = 6'h3F;
	localparam logic [15:0] RST_TEST_PATTERN = 16'h0000;
	localparam logic [3:0]  RST_IRQ_ENABLE   = 4'h0;

	// Sync request pulse timing in clock cycles
	localparam logic [3:0] SYNC_ASSERT_CYCLES = 4'h4;
	localparam logic [3:0] SYNC_GAP_CYCLES    = 4'h2;

	// AHB-Lite encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic       HRESP_OKAY    = 1'b0;

	typedef enum logic [1:0] {
		SYNC_IDLE,
		SYNC_ASSERT,
		SYNC_GAP
	} dfem_sync_state_t;
endpackage

// ===== rtl/dfem_lane_counter.sv
// Three error counters of one lane, with threshold hit detection
module dfem_lane_counter
	import dfem_pkg::*;
#(
	parameter int CW = 8
) (
	input  wire logic                 clk,
	input  wire logic                 reset_n,
	input  wire logic [ERR_TYPES-1:0] errIn,
	input  wire logic [ERR_TYPES-1:0] cntEnable,
	input  wire logic [ERR_TYPES-1:0] cntRun,
	input  wire logic [ERR_TYPES-1:0] autoClear,
	input  wire logic [CW-1:0]        threshold,
	output logic      [ERR_TYPES-1:0] thresholdHit
);
	logic [CW-1:0]        cnt_ff     [ERR_TYPES];
	logic [CW-1:0]        nxt_cnt    [ERR_TYPES];
	logic [ERR_TYPES-1:0] hit_ff;
	logic [ERR_TYPES-1:0] nxt_hit;
	logic [CW-1:0]        cntPlus    [ERR_TYPES];
	logic [ERR_TYPES-1:0] countIt;

	assign thresholdHit = hit_ff;

	// Counters stop at the threshold so one hit is reported once
	always_comb begin
		for (int t = 0; t < ERR_TYPES; t++) begin
			cntPlus[t] = cnt_ff[t] + CW'(1);
			countIt[t] = errIn[t] && cntEnable[t] && cntRun[t];
			nxt_cnt[t] = cnt_ff[t];
			nxt_hit[t] = 1'b0;
			if (!cntRun[t]) begin
				nxt_cnt[t] = '0;                       // R14
			end else if (autoClear[t]) begin
				// An error in the clearing cycle still counts
				nxt_cnt[t] = countIt[t] ? CW'(1) : '0;  // R06
				// Else a threshold of one would freeze without a hit
				nxt_hit[t] = countIt[t] && (threshold == CW'(1));
			end else if (countIt[t] && cnt_ff[t] != threshold) begin
				nxt_cnt[t] = cntPlus[t];                // R08 R10
				nxt_hit[t] = (cntPlus[t] == threshold); // R09
			end
		end
	end

	// Counter and hit registers
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			for (int t = 0; t < ERR_TYPES; t++) begin
				cnt_ff[t] <= '0;
			end
			hit_ff <= '0;
		end else begin
			for (int t = 0; t < ERR_TYPES; t++) begin
				cnt_ff[t] <= nxt_cnt[t];
			end
			hit_ff <= nxt_hit;
		end
	end
endmodule

// ===== rtl/dfem_deframer_error_monitor.sv
// Behaviour
// R01 - With the repeat test bit set, received words are checked against the transport test pattern.
// R02 - Software keeps link test mode clear while the repeat test runs; the test is off otherwise.
// R03 - Software changes test, queue, auto-clear, multiframe and threshold settings only in soft reset.
// R04 - With queued report mode set, errors on several lanes in one cycle give one sync event.
// R05 - With queued report mode clear, lane errors are counted and signalled one by one on sync.
// R06 - With auto-clear on, only the counter whose hit asserted sync is cleared to zero; an error in the clearing cycle loads it with one.
// R07 - The multiframe field gives groups of four multiframes in the ILS, valid 1, 2 or 4, reset 1.
// R08 - Disparity, not-in-table and unexpected-K errors are counted apart against an 8-bit threshold.
// R09 - A count equal to the threshold raises an interrupt, a sync request, or both per the masks.
// R10 - Counting and comparison run in every lane with one shared threshold.
// R11 - Any lane hitting the threshold for a type whose sync mask bit is set asserts sync request; queued mode drops a hit made during a pulse or its gap.
// R12 - Sync mask bit 2 is disparity, bit 1 not-in-table, bit 0 unexpected-K.
// R13 - Link test mode set asks the lane logic for an endless alignment sequence after sync.
// R14 - Counter enable and run fields use bit 2 unexpected-K, bit 1 not-in-table, bit 0 disparity.
// R15 - A type with its sync mask bit clear never asserts sync request, though it may interrupt.
//
// The implementer's own choice: register access over AHB-Lite.
module dfem_deframer_error_monitor
	import dfem_pkg::*;
#(
	parameter int NUM_LANES = 8,
	parameter int PAT_W     = 16
) (
	input  wire logic                 clk,
	input  wire logic                 reset_n,
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic      [31:0]          hrdata,
	output logic                      hreadyout,
	output logic                      hresp,
	input  wire logic [NUM_LANES-1:0] badDisparityError,
	input  wire logic [NUM_LANES-1:0] notInTableError,
	input  wire logic [NUM_LANES-1:0] unexpectedKError,
	input  wire logic                 rxWordValid,
	input  wire logic [PAT_W-1:0]     rxWord,
	output logic                      syncRequestOut,
	output logic                      irq,
	output logic                      deframerSoftReset,
	output logic                      linkTestMode,
	output logic      [7:0]           ilsMultiframeGroups,
	output logic                      patternTestActive
);
	// Bus state
	logic        wrPend_ff, nxt_wrPend;
	logic        rdPend_ff, nxt_rdPend;
	logic [11:0] addrIdx_ff, nxt_addrIdx;
	logic [31:0] hrdata_ff, nxt_hrdata;
	logic        hreadyout_ff, nxt_hreadyout;
	logic        addrPhase;
	logic        wrIdx;
	// Configuration state
	logic [7:0]           softRst_ff, nxt_softRst;
	logic [7:0]           testCtrl_ff, nxt_testCtrl;
	logic [7:0]           mfCount_ff, nxt_mfCount;
	logic [7:0]           thres_ff, nxt_thres;
	logic [2:0]           syncMask_ff, nxt_syncMask;
	logic [PAT_W-1:0]     pattern_ff, nxt_pattern;
	logic [IRQ_BITS-1:0]  irqEn_ff, nxt_irqEn;
	logic [5:0]           ecnt_ff     [NUM_LANES];
	logic [5:0]           nxt_ecnt    [NUM_LANES];
	// Event state
	logic [IRQ_BITS-1:0]  irqStat_ff, nxt_irqStat;
	logic                 irq_ff, nxt_irq;
	logic [IRQ_BITS-1:0]  irqClr;
	logic [IRQ_BITS-1:0]  irqSet;
	logic                 patActive_ff, nxt_patActive;
	// Sync engine
	dfem_sync_state_t     syncSt_ff, nxt_syncSt;
	logic [3:0]           syncTmr_ff, nxt_syncTmr;
	logic [7:0]           pend_ff, nxt_pend;
	logic                 sync_request_out_ff, nxt_sync_request_out;
	// Lane signals
	logic [ERR_TYPES-1:0] laneHit     [NUM_LANES];
	logic [ERR_TYPES-1:0] laneClr     [NUM_LANES];
	logic [NUM_LANES-1:0] laneSyncEvt;
	logic [ERR_TYPES-1:0] typeHit;
	logic [ERR_TYPES-1:0] syncTypeMask;
	logic [7:0]           evtCount;
	logic                 queued;
	logic                 autoClr;

	assign hrdata              = hrdata_ff;
	assign hreadyout           = hreadyout_ff;
	assign hresp               = HRESP_OKAY;
	assign syncRequestOut      = sync_request_out_ff;
	assign irq                 = irq_ff;
	assign deframerSoftReset   = softRst_ff[SOFT_RESET_BIT];
	assign linkTestMode        = testCtrl_ff[LINK_TEST_MODE_BIT]; // R13
	assign ilsMultiframeGroups = mfCount_ff;                     // R07
	assign patternTestActive   = patActive_ff;
	assign queued              = testCtrl_ff[QUEUE_MODE_BIT];
	assign autoClr             = testCtrl_ff[AUTO_CLEAR_BIT];

	// Mask bits are stored reversed against counter order
	assign syncTypeMask[ERR_BDE] = syncMask_ff[2]; // R12
	assign syncTypeMask[ERR_NIT] = syncMask_ff[1]; // R12
	assign syncTypeMask[ERR_UEK] = syncMask_ff[0]; // R12

	// One counter set per lane, all sharing the threshold
	for (genvar l = 0; l < NUM_LANES; l++) begin : g_lane
		dfem_lane_counter #(
			.CW(8)
		) u_cnt (
			.clk          (clk),
			.reset_n      (reset_n),
			.errIn        ({unexpectedKError[l], notInTableError[l],
			                badDisparityError[l]}),         // R14
			.cntEnable    (ecnt_ff[l][ECNT_ENA_LSB +: ERR_TYPES]),
			.cntRun       (ecnt_ff[l][ECNT_RST_LSB +: ERR_TYPES]
			               & {ERR_TYPES{~deframerSoftReset}}),
			.autoClear    (laneClr[l]),
			.threshold    (thres_ff),                       // R10
			.thresholdHit (laneHit[l])
		);
		// Only a type that may raise sync can be auto-cleared
		assign laneSyncEvt[l] = |(laneHit[l] & syncTypeMask); // R11 R15
		assign laneClr[l] = laneHit[l] & syncTypeMask
		                    & {ERR_TYPES{autoClr}};           // R06
	end

	// Reduce lane hits per type and count lanes with sync events
	always_comb begin
		typeHit  = '0;
		evtCount = '0;
		for (int l = 0; l < NUM_LANES; l++) begin
			typeHit  = typeHit | laneHit[l];
			evtCount = evtCount + {7'h00, laneSyncEvt[l]};
		end
	end

	// AHB-Lite slave: writes take no wait, reads take one wait state
	assign addrPhase = hsel && hready && (htrans == HTRANS_NONSEQ
	                   || htrans == 2'h3);
	assign wrIdx     = wrPend_ff;
	always_comb begin
		nxt_wrPend    = 1'b0;
		nxt_rdPend    = 1'b0;
		nxt_addrIdx   = addrIdx_ff;
		nxt_hrdata    = hrdata_ff;
		nxt_hreadyout = 1'b1;
		if (addrPhase) begin
			nxt_addrIdx   = haddr[ADDR_LSB +: 12];
			nxt_wrPend    = hwrite;
			nxt_rdPend    = !hwrite;
			nxt_hreadyout = hwrite;
		end
		// Read in the wait cycle so a write just before is seen
		if (rdPend_ff) begin
			nxt_hrdata = 32'h0000_0000;
			case (addrIdx_ff)
				IDX_SOFT_RESET:   nxt_hrdata[7:0] = softRst_ff;
				IDX_TEST_CTRL:    nxt_hrdata[7:0] = testCtrl_ff;
				IDX_ILS_MF_COUNT: nxt_hrdata[7:0] = mfCount_ff;
				IDX_ERR_THRES:    nxt_hrdata[7:0] = thres_ff;
				IDX_SYNC_MASK:    nxt_hrdata[2:0] = syncMask_ff;
				IDX_TEST_PATTERN: nxt_hrdata[PAT_W-1:0] = pattern_ff;
				IDX_IRQ_STATUS:   nxt_hrdata[IRQ_BITS-1:0] = irqStat_ff;
				IDX_IRQ_ENABLE:   nxt_hrdata[IRQ_BITS-1:0] = irqEn_ff;
				IDX_SYNC_PENDING: nxt_hrdata[7:0] = pend_ff;
				default: begin
					for (int l = 0; l < NUM_LANES; l++) begin
						if (addrIdx_ff == IDX_LANE0_ERROR_COUNTER_CONTROL + 12'(l)) begin
							nxt_hrdata[5:0] = ecnt_ff[l];
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			wrPend_ff    <= 1'b0;
			rdPend_ff    <= 1'b0;
			addrIdx_ff   <= '0;
			hrdata_ff    <= 32'h0000_0000;
			hreadyout_ff <= 1'b1;
		end else begin
			wrPend_ff    <= nxt_wrPend;
			rdPend_ff    <= nxt_rdPend;
			addrIdx_ff   <= nxt_addrIdx;
			hrdata_ff    <= nxt_hrdata;
			hreadyout_ff <= nxt_hreadyout;
		end
	end

	// Configuration writes; settings are meant to change in soft reset
	always_comb begin
		nxt_softRst  = softRst_ff;
		nxt_testCtrl = testCtrl_ff;
		nxt_mfCount  = mfCount_ff;
		nxt_thres    = thres_ff;
		nxt_syncMask = syncMask_ff;
		nxt_pattern  = pattern_ff;
		nxt_irqEn    = irqEn_ff;
		irqClr       = '0;
		for (int l = 0; l < NUM_LANES; l++) begin
			nxt_ecnt[l] = ecnt_ff[l];
			if (wrIdx && addrIdx_ff == IDX_LANE0_ERROR_COUNTER_CONTROL + 12'(l)) begin
				nxt_ecnt[l] = hwdata[5:0];                     // R14
			end
		end
		if (wrIdx) begin
			case (addrIdx_ff)
				IDX_SOFT_RESET:   nxt_softRst  = hwdata[7:0] & 8'h08;
				IDX_TEST_CTRL:    nxt_testCtrl = hwdata[7:0] & 8'hB8; // R03
				IDX_ILS_MF_COUNT: nxt_mfCount  = hwdata[7:0];  // R07
				IDX_ERR_THRES:    nxt_thres    = hwdata[7:0];  // R08
				IDX_SYNC_MASK:    nxt_syncMask = hwdata[2:0];  // R12
				IDX_TEST_PATTERN: nxt_pattern  = hwdata[PAT_W-1:0];
				IDX_IRQ_ENABLE:   nxt_irqEn    = hwdata[IRQ_BITS-1:0];
				IDX_IRQ_CLEAR:    irqClr       = hwdata[IRQ_BITS-1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			softRst_ff  <= RST_SOFT_RESET;
			testCtrl_ff <= RST_TEST_CTRL;
			mfCount_ff  <= RST_ILS_MF_COUNT;
			thres_ff    <= RST_ERR_THRES;
			syncMask_ff <= RST_SYNC_MASK;
			pattern_ff  <= RST_TEST_PATTERN;
			irqEn_ff    <= RST_IRQ_ENABLE;
			for (int l = 0; l < NUM_LANES; l++) begin
				ecnt_ff[l] <= RST_ECNT_CTRL;
			end
		end else begin
			softRst_ff  <= nxt_softRst;
			testCtrl_ff <= nxt_testCtrl;
			mfCount_ff  <= nxt_mfCount;
			thres_ff    <= nxt_thres;
			syncMask_ff <= nxt_syncMask;
			pattern_ff  <= nxt_pattern;
			irqEn_ff    <= nxt_irqEn;
			for (int l = 0; l < NUM_LANES; l++) begin
				ecnt_ff[l] <= nxt_ecnt[l];
			end
		end
	end

	// Pattern test and sticky interrupt status; a set beats a clear
	always_comb begin
		nxt_patActive = testCtrl_ff[REPEAT_TEST_BIT]
		                && !testCtrl_ff[LINK_TEST_MODE_BIT]  // R02
		                && !deframerSoftReset;
		irqSet = {1'b0, typeHit};                           // R09
		irqSet[IRQ_PATTERN_BIT] = patActive_ff && rxWordValid
		                          && rxWord != pattern_ff;  // R01
		nxt_irqStat = (irqStat_ff & ~irqClr) | irqSet;
		nxt_irq     = |(nxt_irqStat & irqEn_ff);            // R09
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			patActive_ff <= 1'b0;
			irqStat_ff   <= '0;
			irq_ff       <= 1'b0;
		end else begin
			patActive_ff <= nxt_patActive;
			irqStat_ff   <= nxt_irqStat;
			irq_ff       <= nxt_irq;
		end
	end

	// Sync request pulses; a gap keeps queued pulses distinguishable
	always_comb begin
		nxt_syncSt  = syncSt_ff;
		nxt_syncTmr = syncTmr_ff;
		nxt_sync_request_out = 1'b0;
		nxt_pend    = pend_ff;
		if (!queued) begin
			// Saturate rather than wrap under an error storm
			if (9'(pend_ff) + 9'(evtCount) > 9'h0FF) begin
				nxt_pend = 8'hFF;
			end else begin
				nxt_pend = pend_ff + evtCount;               // R05
			end
		end
		case (syncSt_ff)
			SYNC_IDLE: begin
				if (queued ? (evtCount != 8'h00) : (nxt_pend != 8'h00)) begin
					nxt_syncSt  = SYNC_ASSERT;
					nxt_syncTmr = SYNC_ASSERT_CYCLES - 4'h1;
					nxt_sync_request_out = 1'b1;                      // R04 R11
					if (!queued) begin
						nxt_pend = nxt_pend - 8'h01;         // R05
					end
				end
			end
			SYNC_ASSERT: begin
				nxt_sync_request_out = 1'b1;
				if (syncTmr_ff == 4'h0) begin
					nxt_sync_request_out = 1'b0;
					nxt_syncSt  = SYNC_GAP;
					nxt_syncTmr = SYNC_GAP_CYCLES - 4'h1;
				end else begin
					nxt_syncTmr = syncTmr_ff - 4'h1;
				end
			end
			SYNC_GAP: begin
				if (syncTmr_ff == 4'h0) begin
					nxt_syncSt = SYNC_IDLE;
				end else begin
					nxt_syncTmr = syncTmr_ff - 4'h1;
				end
			end
			default: nxt_syncSt = SYNC_IDLE;
		endcase
		if (deframerSoftReset) begin
			nxt_pend = 8'h00;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			syncSt_ff  <= SYNC_IDLE;
			syncTmr_ff <= 4'h0;
			pend_ff    <= 8'h00;
			sync_request_out_ff <= 1'b0;
		end else begin
			syncSt_ff  <= nxt_syncSt;
			syncTmr_ff <= nxt_syncTmr;
			pend_ff    <= nxt_pend;
			sync_request_out_ff <= nxt_sync_request_out;
		end
	end
endmodule

// ===== verification/dfem_monitor_sva.sv
// Port-level checks for the error monitor; bound into every instance
module dfem_monitor_sva
	import dfem_pkg::*;
(
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        syncRequestOut,
	input wire logic        irq,
	input wire logic        deframerSoftReset,
	input wire logic        linkTestMode,
	input wire logic [7:0]  ilsMultiframeGroups,
	input wire logic        patternTestActive
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	// Transfer accepted in its address phase
	logic taken;
	assign taken = hsel && hready && htrans[1];

	a_read_wait: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read data phase not exactly one wait");
	a_write_fast: assert property (taken && hwrite |=> hreadyout)
		else $error("write data phase stalled");
	a_wait_single: assert property (!hreadyout |=> hreadyout)
		else $error("wait state longer than one cycle");
	a_sync_shape: assert property ($rose(syncRequestOut) |->
		syncRequestOut[*4] ##1 !syncRequestOut[*2])
		else $error("sync request pulse or gap has wrong length");
	a_mf_write: assert property (taken && hwrite &&
		haddr[13:2] == IDX_ILS_MF_COUNT |=> ##1
		ilsMultiframeGroups == $past(hwdata[7:0]))
		else $error("multiframe count did not follow write");
	a_softrst_write: assert property (taken && hwrite &&
		haddr[13:2] == IDX_SOFT_RESET |=> ##1
		deframerSoftReset == $past(hwdata[SOFT_RESET_BIT]))
		else $error("soft reset output did not follow write");
	a_pattern_gate: assert property (
		linkTestMode || deframerSoftReset |=> !patternTestActive)
		else $error("pattern test active while gated off");
	a_reset_state: assert property ($rose(reset_n) |->
		ilsMultiframeGroups == RST_ILS_MF_COUNT && !syncRequestOut && !irq)
		else $error("outputs wrong right after reset");

	// Main scenarios reached
	c_sync: cover property ($rose(syncRequestOut));
	c_irq: cover property ($rose(irq));
	c_pattern: cover property (patternTestActive);
endmodule

bind dfem_deframer_error_monitor dfem_monitor_sva sva_u (
	.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .syncRequestOut(syncRequestOut), .irq(irq),
	.deframerSoftReset(deframerSoftReset), .linkTestMode(linkTestMode),
	.ilsMultiframeGroups(ilsMultiframeGroups),
	.patternTestActive(patternTestActive)
);

// ===== verification/dfem_tx_model.sv
// Far-end transmitter: lane error pulses and received words
module dfem_tx_model
	import dfem_pkg::*;
#(
	parameter int NUM_LANES = 8,
	parameter int PAT_W     = 16
) (
	input  wire logic                 clk,
	output logic      [NUM_LANES-1:0] badDisparityError,
	output logic      [NUM_LANES-1:0] notInTableError,
	output logic      [NUM_LANES-1:0] unexpectedKError,
	output logic                      rxWordValid,
	output logic      [PAT_W-1:0]     rxWord
);
	timeunit 1ns;
	timeprecision 1ps;

	// Quiet link at start
	initial begin
		badDisparityError = '0;
		notInTableError = '0;
		unexpectedKError = '0;
		rxWordValid = 1'b0;
		rxWord = '0;
	end

	// One-cycle pulse per selected lane and type; a spare cycle after it
	task automatic sendErr(input logic [NUM_LANES-1:0] lanes,
		input logic [2:0] ty);
		badDisparityError <= ty[ERR_BDE] ? lanes : '0;
		notInTableError <= ty[ERR_NIT] ? lanes : '0;
		unexpectedKError <= ty[ERR_UEK] ? lanes : '0;
		@(posedge clk);
		badDisparityError <= '0;
		notInTableError <= '0;
		unexpectedKError <= '0;
		@(posedge clk);
	endtask

	// Stale data is inverted so an idle bus never looks valid
	task automatic sendWord(input logic [PAT_W-1:0] w);
		rxWordValid <= 1'b1;
		rxWord <= w;
		@(posedge clk);
		rxWordValid <= 1'b0;
		rxWord <= ~w;
		@(posedge clk);
	endtask
endmodule

// ===== verification/tb_top.sv
// Self-checking bench for the deframer error monitor
module tb_top
	import dfem_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk;
	logic        reset_n;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic        hready;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [7:0]  badDisparityError;
	logic [7:0]  notInTableError;
	logic [7:0]  unexpectedKError;
	logic        rxWordValid;
	logic [15:0] rxWord;
	logic        syncRequestOut;
	logic        irq;
	logic        deframerSoftReset;
	logic        linkTestMode;
	logic [7:0]  ilsMultiframeGroups;
	logic        patternTestActive;
	int          badCount;
	int          testsRun;

	// Single slave, so its ready is the bus ready
	assign hready = hreadyout;

	dfem_deframer_error_monitor dut_u (
		.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .badDisparityError(badDisparityError),
		.notInTableError(notInTableError),
		.unexpectedKError(unexpectedKError), .rxWordValid(rxWordValid),
		.rxWord(rxWord), .syncRequestOut(syncRequestOut), .irq(irq),
		.deframerSoftReset(deframerSoftReset), .linkTestMode(linkTestMode),
		.ilsMultiframeGroups(ilsMultiframeGroups),
		.patternTestActive(patternTestActive)
	);

	dfem_tx_model tx_u (
		.clk(clk), .badDisparityError(badDisparityError),
		.notInTableError(notInTableError),
		.unexpectedKError(unexpectedKError), .rxWordValid(rxWordValid),
		.rxWord(rxWord)
	);

	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic printVerdict();
		$display("checks %0d mismatches %0d", testsRun, badCount);
		if (badCount == 0 && testsRun > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, exp);
		testsRun++;
		if (seen !== exp) begin
			badCount++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Bounded wait for ready at a rising edge
	task automatic waitReady();
		int n;
		n = 0;
		@(posedge clk);
		while (hready !== 1'b1) begin
			n++;
			if (n > 20) begin
				badCount++;
				printVerdict();
			end
			@(posedge clk);
		end
	endtask

	// One AHB-Lite single word transfer
	task automatic busXfer(input logic wr, input logic [11:0] idx,
		input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= {18'h0, idx, 2'h0};
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		waitReady();
		htrans <= 2'h0;
		hwdata <= d;
		waitReady();
		q = hrdata;
	endtask

	task automatic bw(input logic [11:0] idx, input logic [31:0] d);
		logic [31:0] q;
		busXfer(1'b1, idx, d, q);
	endtask

	task automatic br(input logic [11:0] idx, output logic [31:0] q);
		busXfer(1'b0, idx, 32'h0, q);
	endtask

	// Settings change only inside soft reset, which also empties counters
	task automatic cfg(input logic [7:0] tc, thr, mask);
		bw(IDX_SOFT_RESET, 32'h8);
		bw(IDX_TEST_CTRL, {24'h0, tc});
		bw(IDX_ERR_THRES, {24'h0, thr});
		bw(IDX_SYNC_MASK, {24'h0, mask});
		bw(IDX_IRQ_CLEAR, 32'hF);
		bw(IDX_IRQ_ENABLE, 32'hF);
		bw(IDX_SOFT_RESET, 32'h0);
	endtask

	// Rising edges of sync request over a window
	task automatic countSync(input int cyc, output int c);
		logic prv;
		c = 0;
		prv = syncRequestOut;
		repeat (cyc) begin
			@(posedge clk);
			if (syncRequestOut === 1'b1 && prv !== 1'b1) c++;
			prv = syncRequestOut;
		end
	endtask

	// Reset values, a hole in the map, multiframe write
	task automatic sRegs();
		logic [31:0] q;
		br(IDX_ILS_MF_COUNT, q);
		chk("mf", q, 32'h1);
		br(IDX_ERR_THRES, q);
		chk("thres", q, 32'hFF);
		br(IDX_SYNC_MASK, q);
		chk("mask", q, 32'h7);
		br(IDX_LANE0_ERROR_COUNTER_CONTROL + 12'h7, q);
		chk("ecnt", q, 32'h3F);
		bw(12'h400, 32'hFF);
		br(12'h400, q);
		chk("hole", q, 32'h0);
		chk("hresp", hresp, HRESP_OKAY);
		bw(IDX_SOFT_RESET, 32'h8);
		bw(IDX_ILS_MF_COUNT, 32'h4);
		br(IDX_ILS_MF_COUNT, q);
		chk("mf4", q, 32'h4);
		chk("mfport", ilsMultiframeGroups, 32'h4);
		bw(IDX_SOFT_RESET, 32'h0);
	endtask

	// Threshold of two, irq raised and cleared
	task automatic sHit();
		logic [31:0] q;
		int c;
		cfg(8'h10, 8'h02, 8'h07);
		tx_u.sendErr(8'h02, 3'h1);
		countSync(12, c);
		chk("below", c, 0);
		tx_u.sendErr(8'h02, 3'h1);
		countSync(12, c);
		chk("hit", c, 1);
		chk("irq", irq, 1'b1);
		br(IDX_IRQ_STATUS, q);
		chk("stat", q, 32'h1);
		bw(IDX_IRQ_CLEAR, 32'h7);
		repeat (3) @(posedge clk);
		chk("irqclr", irq, 1'b0);
	endtask

	// Each mask bit, reversed order, on the last lane
	task automatic sMask();
		logic [31:0] q;
		int c;
		for (int t = 0; t < 3; t++) begin
			cfg(8'h10, 8'h01, 8'(1 << (2 - t)));
			tx_u.sendErr(8'h80, 3'(1 << ((t + 1) % 3)));
			countSync(12, c);
			chk("unmasked", c, 0);
			tx_u.sendErr(8'h80, 3'(1 << t));
			countSync(12, c);
			chk("masked", c, 1);
			br(IDX_IRQ_STATUS, q);
			chk("stat", q, 32'((1 << t) | (1 << ((t + 1) % 3))));
		end
	endtask

	// Three lanes hit together: merged, then queued
	task automatic sQueue();
		int c;
		for (int m = 0; m < 2; m++) begin
			cfg(m ? 8'h00 : 8'h10, 8'h01, 8'h07);
			tx_u.sendErr(8'h07, 3'h1);
			countSync(40, c);
			chk("pulses", c, m ? 3 : 1);
		end
	endtask

	// Second error re-hits only when auto clear is on
	task automatic sAutoClr();
		int c;
		for (int a = 0; a < 2; a++) begin
			cfg(a ? 8'h18 : 8'h10, 8'h01, 8'h07);
			tx_u.sendErr(8'h04, 3'h2);
			countSync(12, c);
			chk("first", c, 1);
			tx_u.sendErr(8'h04, 3'h2);
			countSync(12, c);
			chk("again", c, a);
		end
	endtask

	// Lane 0 counts only disparity errors with its other enables off
	task automatic sEnable();
		logic [31:0] q;
		int c;
		cfg(8'h10, 8'h01, 8'h07);
		bw(IDX_LANE0_ERROR_COUNTER_CONTROL, 32'h0F);
		tx_u.sendErr(8'h01, 3'h6);
		countSync(12, c);
		chk("disabled", c, 0);
		tx_u.sendErr(8'h01, 3'h1);
		countSync(12, c);
		chk("enabled", c, 1);
		br(IDX_IRQ_STATUS, q);
		chk("enstat", q, 32'h1);
		bw(IDX_LANE0_ERROR_COUNTER_CONTROL, 32'h3F);
	endtask

	// Repeat pattern test, then gated off by link test mode
	task automatic sPattern();
		logic [31:0] q;
		bw(IDX_TEST_PATTERN, 32'h1234);
		cfg(8'h20, 8'hFF, 8'h07);
		repeat (2) @(posedge clk);
		chk("active", patternTestActive, 1'b1);
		tx_u.sendWord(16'h1234);
		br(IDX_IRQ_STATUS, q);
		chk("match", q, 32'h0);
		tx_u.sendWord(16'h1235);
		br(IDX_IRQ_STATUS, q);
		chk("mismatch", q, 32'h8);
		chk("irqpat", irq, 1'b1);
		cfg(8'hA0, 8'hFF, 8'h07);
		repeat (2) @(posedge clk);
		chk("ltm", linkTestMode, 1'b1);
		chk("gated", patternTestActive, 1'b0);
	endtask

	// Reset, then the scenarios in turn
	initial begin
		badCount = 0;
		testsRun = 0;
		reset_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		sRegs();
		sHit();
		sMask();
		sQueue();
		sAutoClr();
		sEnable();
		sPattern();
		printVerdict();
	end
endmodule
